/* verilog/flash_seq_pkg.sv */
package flash_seq_pkg;
	// Behaviour
	// - Burst keeps pump on if next queued early
	// - Pump held only within same 64-byte row
	// - Program/erase pump on at start, off after
	// - Sequence violation sets error, command discarded
	// - Program/erase before divider written is error
	// - Stop entry during command sets error
	// - Error flag clears by writing one
	// - Blank check all erased sets blank flag
	// - Valid launch clears blank flag; writes ignored
	// - Blank flag zero after check means dirty
	// - Codes 0x05, 0x20, 0x25 accepted
	// - Codes 0x40 page, 0x41 mass erase
	// - Other codes illegal, error, no operation

	// Register byte offsets on the APB slave
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_ADDR = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0c;
	localparam logic [7:0] OFS_CLKDIV = 8'h10;
	localparam logic [7:0] OFS_INT_ST = 8'h14;
	localparam logic [7:0] OFS_INT_MASK = 8'h18;

	// Status flag bit positions
	localparam int ST_CBEF = 7;
	localparam int ST_CCF = 6;
	localparam int ST_ACCERR = 4;
	localparam int ST_BLANK = 2;

	// Reset values
	localparam logic CBEF_RST = 1'b1;
	localparam logic [1:0] INT_MASK_RST = 2'h0;

	// Command codes
	localparam logic [7:0] CMD_BLANK = 8'h05;
	localparam logic [7:0] CMD_BYTE = 8'h20;
	localparam logic [7:0] CMD_BURST = 8'h25;
	localparam logic [7:0] CMD_PAGE = 8'h40;
	localparam logic [7:0] CMD_MASS = 8'h41;

	// Array geometry
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam int ROW_BITS = 6;

	// Interrupt status bits
	localparam int INT_W = 2;
	localparam int INT_DONE = 0;
	localparam int INT_ERR = 1;

	// Divider register layout: value bits plus a written marker on read
	localparam int DIV_W = 7;
	localparam int DIV_SET_BIT = 7;

	// Operation times in microseconds and their cycle counts
	localparam int CLK_PERIOD_NS = 100;
	localparam int PROG_TIME_US = 20;
	localparam int BURST_TIME_US = 14;
	localparam int PAGE_TIME_US = 20000;
	localparam int MASS_TIME_US = 100000;
	localparam int PROG_CYC = (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BURST_CYC = (BURST_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PAGE_CYC = (PAGE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MASS_CYC = (MASS_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMR_W = 24;

	// Sequencer states
	typedef enum logic [2:0] {S_IDLE, S_PROG, S_ERASE, S_BLANK_RD, S_BLANK_CMP} state_e;
endpackage

/* verilog/op_timer.sv */
`timescale 1ns/1ps
module op_timer #(
	parameter int W = 24
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic abort,
	input wire logic [W-1:0] load,
	output logic busy,
	output logic done
);
	logic [W-1:0] count_q, count_d; // Cycles left
	logic done_q, done_d; // Expiry pulse

	// Load wins over counting; abort wins over both
	always_comb begin
		count_d = count_q;
		done_d = 1'b0;
		if (abort) begin
			count_d = '0;
		end else if (start) begin
			count_d = load;
		end else if (count_q != '0) begin
			count_d = count_q - 1'b1;
			// Pulse lands one cycle after the last count
			if (count_q == {{(W-1){1'b0}}, 1'b1}) begin
				done_d = 1'b1;
			end
		end
	end

	// Register stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= '0;
			done_q <= 1'b0;
		end else begin
			count_q <= count_d;
			done_q <= done_d;
		end
	end

	assign busy = (count_q != '0);
	assign done = done_q;
endmodule

/* verilog/flash_command_sequencer.sv */
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module flash_command_sequencer
	import flash_seq_pkg::*;
#(
	parameter int ADDR_W = 13,
	parameter int PAGE_CYCLES = PAGE_CYC,
	parameter int MASS_CYCLES = MASS_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic stop_entry,
	output logic [ADDR_W-1:0] arr_addr,
	output logic [7:0] arr_wdata,
	input wire logic [7:0] arr_rdata,
	output logic arr_rd,
	output logic arr_prog,
	output logic arr_page_erase,
	output logic arr_mass_erase,
	output logic pump_en
);
	// Bus phase decode
	logic setup; // First cycle of a transfer
	logic access; // Access phase, completes at once
	logic mapped; // Address hits a register
	logic wr_st, wr_cmd, wr_addr, wr_data, wr_div, wr_ist, wr_imask;

	// Software-visible state
	state_e state_q, state_d; // Sequencer state
	logic cbef_q, cbef_d; // Command buffer empty flag
	logic accerr_q, accerr_d; // Access error flag
	logic blank_q, blank_d; // Blank verified flag
	logic ccf_q; // Command complete, registered for edge detect
	logic ccf_d;
	logic [7:0] cmd_q, cmd_d; // Last legal code written
	logic cmd_vld_q, cmd_vld_d; // A code waits for launch
	logic [ADDR_W-1:0] addr_q, addr_d; // Target address
	logic [7:0] data_q, data_d; // Program data
	logic [DIV_W-1:0] div_q, div_d; // Clock divider value
	logic div_set_q, div_set_d; // Divider written since reset

	// One-deep command queue and the running operation
	logic [7:0] buf_cmd_q, buf_cmd_d;
	logic [ADDR_W-1:0] buf_addr_q, buf_addr_d;
	logic [7:0] buf_data_q, buf_data_d;
	logic [7:0] act_cmd_q, act_cmd_d;
	logic [ADDR_W-1:0] act_addr_q, act_addr_d;

	// Array side
	logic pump_q, pump_d;
	logic [ADDR_W-1:0] arr_addr_q, arr_addr_d;
	logic [7:0] arr_wdata_q, arr_wdata_d;
	logic arr_rd_q, arr_rd_d;
	logic arr_prog_q, arr_prog_d;
	logic arr_page_q, arr_page_d;
	logic arr_mass_q, arr_mass_d;
	logic [ADDR_W-1:0] scan_q, scan_d; // Blank check walk pointer
	logic scan_ok_q, scan_ok_d; // No dirty byte seen yet

	// Interrupt and bus read state
	logic [INT_W-1:0] int_st_q, int_st_d;
	logic [INT_W-1:0] int_mask_q, int_mask_d;
	logic [31:0] prdata_q, prdata_d;

	// Timer hookup and event terms
	logic tmr_start, tmr_abort, tmr_done;
	logic [TMR_W-1:0] tmr_load;
	logic err_ev; // Any access error this cycle
	logic launch_try, launch_ok;
	logic same_row, keep_pump;
	logic [7:0] status_rd;

	// Only the five documented codes are legal
	function automatic logic legal_code(input logic [7:0] c);
		case (c)
			CMD_BLANK, CMD_BYTE, CMD_BURST: legal_code = 1'b1;
			CMD_PAGE, CMD_MASS: legal_code = 1'b1;
			default: legal_code = 1'b0;
		endcase
	endfunction

	op_timer #(.W(TMR_W)) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.start(tmr_start),
		.abort(tmr_abort),
		.load(tmr_load),
		.busy(),
		.done(tmr_done)
	);

	// Address decode; zero wait states so pready is constant
	always_comb begin
		setup = psel && !penable;
		access = psel && penable;
		case (paddr)
			OFS_STATUS, OFS_CMD, OFS_ADDR, OFS_DATA: mapped = 1'b1;
			OFS_CLKDIV, OFS_INT_ST, OFS_INT_MASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
		wr_st = access && pwrite && (paddr == OFS_STATUS);
		wr_cmd = access && pwrite && (paddr == OFS_CMD);
		wr_addr = access && pwrite && (paddr == OFS_ADDR);
		wr_data = access && pwrite && (paddr == OFS_DATA);
		wr_div = access && pwrite && (paddr == OFS_CLKDIV);
		wr_ist = access && pwrite && (paddr == OFS_INT_ST);
		wr_imask = access && pwrite && (paddr == OFS_INT_MASK);
	end

	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	// Burst pump hold test, judged on the cycle the byte finishes
	always_comb begin
		same_row = (buf_addr_q[ADDR_W-1:ROW_BITS] == act_addr_q[ADDR_W-1:ROW_BITS]);
		keep_pump = (act_cmd_q == CMD_BURST) && !cbef_q && (buf_cmd_q == CMD_BURST) && same_row;
		launch_try = wr_st && pwdata[ST_CBEF] && cbef_q && !accerr_q;
		launch_ok = launch_try && cmd_vld_q && ((cmd_q == CMD_BLANK) || div_set_q);
		status_rd = '0;
		status_rd[ST_CBEF] = cbef_q;
		status_rd[ST_CCF] = ccf_q;
		status_rd[ST_ACCERR] = accerr_q;
		status_rd[ST_BLANK] = blank_q;
	end

	// Read data captured in setup so it is stable through access
	always_comb begin
		prdata_d = prdata_q;
		if (setup) begin
			case (paddr)
				OFS_STATUS: prdata_d = {24'h0, status_rd};
				OFS_ADDR: prdata_d = {{(32-ADDR_W){1'b0}}, addr_q};
				OFS_DATA: prdata_d = {24'h0, data_q};
				OFS_CLKDIV: prdata_d = {24'h0, div_set_q, div_q};
				OFS_INT_ST: prdata_d = {{(32-INT_W){1'b0}}, int_st_q};
				OFS_INT_MASK: prdata_d = {{(32-INT_W){1'b0}}, int_mask_q};
				default: prdata_d = 32'h0; // Command register is write-only
			endcase
		end
	end

	// Command acceptance, launch and the sequencer itself
	always_comb begin
		state_d = state_q;
		cbef_d = cbef_q;
		accerr_d = accerr_q;
		blank_d = blank_q;
		cmd_d = cmd_q;
		cmd_vld_d = cmd_vld_q;
		addr_d = addr_q;
		data_d = data_q;
		div_d = div_q;
		div_set_d = div_set_q;
		buf_cmd_d = buf_cmd_q;
		buf_addr_d = buf_addr_q;
		buf_data_d = buf_data_q;
		act_cmd_d = act_cmd_q;
		act_addr_d = act_addr_q;
		pump_d = pump_q;
		arr_addr_d = arr_addr_q;
		arr_wdata_d = arr_wdata_q;
		arr_rd_d = 1'b0;
		arr_prog_d = arr_prog_q;
		arr_page_d = arr_page_q;
		arr_mass_d = arr_mass_q;
		scan_d = scan_q;
		scan_ok_d = scan_ok_q;
		tmr_start = 1'b0;
		tmr_abort = 1'b0;
		tmr_load = '0;
		err_ev = 1'b0;

		// Write-one-to-clear; a new error later in this block still wins
		if (wr_st && pwdata[ST_ACCERR]) begin
			accerr_d = 1'b0;
		end
		if (wr_addr) begin
			addr_d = pwdata[ADDR_W-1:0];
		end
		if (wr_data) begin
			data_d = pwdata[7:0];
		end
		if (wr_div) begin
			div_d = pwdata[DIV_W-1:0];
			div_set_d = 1'b1;
		end
		// A code written while the buffer is full or an unknown code is dropped
		if (wr_cmd) begin
			if (!cbef_q || !legal_code(pwdata[7:0])) begin
				err_ev = 1'b1;
			end else begin
				cmd_d = pwdata[7:0];
				cmd_vld_d = 1'b1;
			end
		end
		// Launch: blocked silently while an error is pending
		if (launch_try) begin
			if (!cmd_vld_q) begin
				err_ev = 1'b1;
			end else if (!launch_ok) begin
				err_ev = 1'b1;
				cmd_vld_d = 1'b0;
			end else begin
				buf_cmd_d = cmd_q;
				buf_addr_d = addr_q;
				buf_data_d = data_q;
				cbef_d = 1'b0;
				blank_d = 1'b0;
				cmd_vld_d = 1'b0;
			end
		end

		case (state_q)
			S_IDLE: begin
				// Pull a queued command; the buffer frees for the next one
				if (!cbef_q) begin
					cbef_d = 1'b1;
					act_cmd_d = buf_cmd_q;
					act_addr_d = buf_addr_q;
					arr_addr_d = buf_addr_q;
					arr_wdata_d = buf_data_q;
					case (buf_cmd_q)
						CMD_BLANK: begin
							scan_d = '0;
							scan_ok_d = 1'b1;
							state_d = S_BLANK_RD;
						end
						CMD_BYTE, CMD_BURST: begin
							pump_d = 1'b1;
							arr_prog_d = 1'b1;
							tmr_start = 1'b1;
							// A pump already up skips its ramp, so the burst byte is shorter
							tmr_load = (pump_q && buf_cmd_q == CMD_BURST) ? TMR_W'(BURST_CYC) : TMR_W'(PROG_CYC);
							state_d = S_PROG;
						end
						CMD_PAGE: begin
							pump_d = 1'b1;
							arr_page_d = 1'b1;
							tmr_start = 1'b1;
							tmr_load = TMR_W'(PAGE_CYCLES);
							state_d = S_ERASE;
						end
						CMD_MASS: begin
							pump_d = 1'b1;
							arr_mass_d = 1'b1;
							tmr_start = 1'b1;
							tmr_load = TMR_W'(MASS_CYCLES);
							state_d = S_ERASE;
						end
						default: state_d = S_IDLE;
					endcase
				end
			end
			S_PROG, S_ERASE: begin
				if (tmr_done) begin
					arr_prog_d = 1'b0;
					arr_page_d = 1'b0;
					arr_mass_d = 1'b0;
					state_d = S_IDLE;
					// Pump stays up only for an early queued burst in the same row
					if (!keep_pump) begin
						pump_d = 1'b0;
					end
				end
			end
			S_BLANK_RD: begin
				arr_rd_d = 1'b1;
				arr_addr_d = scan_q;
				state_d = S_BLANK_CMP;
			end
			S_BLANK_CMP: begin
				// First dirty byte ends the walk early
				if (arr_rdata != ERASED_BYTE) begin
					scan_ok_d = 1'b0;
					state_d = S_IDLE;
				end else if (scan_q == {ADDR_W{1'b1}}) begin
					blank_d = scan_ok_q;
					state_d = S_IDLE;
				end else begin
					scan_d = scan_q + 1'b1;
					state_d = S_BLANK_RD;
				end
			end
			default: state_d = S_IDLE;
		endcase

		// Stop entry aborts everything, queued work included
		if (stop_entry && (state_q != S_IDLE || !cbef_q)) begin
			err_ev = 1'b1;
			state_d = S_IDLE;
			cbef_d = 1'b1;
			pump_d = 1'b0;
			arr_prog_d = 1'b0;
			arr_page_d = 1'b0;
			arr_mass_d = 1'b0;
			arr_rd_d = 1'b0;
			tmr_start = 1'b0;
			tmr_abort = 1'b1;
		end
		if (err_ev) begin
			accerr_d = 1'b1;
		end
	end

	// Sticky interrupt events; setting beats a simultaneous clear
	always_comb begin
		ccf_d = cbef_d && (state_d == S_IDLE);
		int_st_d = int_st_q;
		int_mask_d = int_mask_q;
		if (wr_ist) begin
			int_st_d = int_st_q & ~pwdata[INT_W-1:0];
		end
		if (wr_imask) begin
			int_mask_d = pwdata[INT_W-1:0];
		end
		if (ccf_d && !ccf_q) begin
			int_st_d[INT_DONE] = 1'b1;
		end
		if (err_ev) begin
			int_st_d[INT_ERR] = 1'b1;
		end
	end

	// Register stage for all groups
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= S_IDLE;
			cbef_q <= CBEF_RST;
			accerr_q <= 1'b0;
			blank_q <= 1'b0;
			ccf_q <= 1'b1;
			cmd_q <= '0;
			cmd_vld_q <= 1'b0;
			addr_q <= '0;
			data_q <= '0;
			div_q <= '0;
			div_set_q <= 1'b0;
			buf_cmd_q <= '0;
			buf_addr_q <= '0;
			buf_data_q <= '0;
			act_cmd_q <= '0;
			act_addr_q <= '0;
			pump_q <= 1'b0;
			arr_addr_q <= '0;
			arr_wdata_q <= '0;
			arr_rd_q <= 1'b0;
			arr_prog_q <= 1'b0;
			arr_page_q <= 1'b0;
			arr_mass_q <= 1'b0;
			scan_q <= '0;
			scan_ok_q <= 1'b0;
			int_st_q <= '0;
			int_mask_q <= INT_MASK_RST;
			prdata_q <= '0;
		end else begin
			state_q <= state_d;
			cbef_q <= cbef_d;
			accerr_q <= accerr_d;
			blank_q <= blank_d;
			ccf_q <= ccf_d;
			cmd_q <= cmd_d;
			cmd_vld_q <= cmd_vld_d;
			addr_q <= addr_d;
			data_q <= data_d;
			div_q <= div_d;
			div_set_q <= div_set_d;
			buf_cmd_q <= buf_cmd_d;
			buf_addr_q <= buf_addr_d;
			buf_data_q <= buf_data_d;
			act_cmd_q <= act_cmd_d;
			act_addr_q <= act_addr_d;
			pump_q <= pump_d;
			arr_addr_q <= arr_addr_d;
			arr_wdata_q <= arr_wdata_d;
			arr_rd_q <= arr_rd_d;
			arr_prog_q <= arr_prog_d;
			arr_page_q <= arr_page_d;
			arr_mass_q <= arr_mass_d;
			scan_q <= scan_d;
			scan_ok_q <= scan_ok_d;
			int_st_q <= int_st_d;
			int_mask_q <= int_mask_d;
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;
	assign irq = |(int_st_q & int_mask_q);
	assign pump_en = pump_q;
	assign arr_addr = arr_addr_q;
	assign arr_wdata = arr_wdata_q;
	assign arr_rd = arr_rd_q;
	assign arr_prog = arr_prog_q;
	assign arr_page_erase = arr_page_q;
	assign arr_mass_erase = arr_mass_q;

	// Checks on the sequencer's own outputs
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_burst_hold: assert property ((state_q == S_PROG) && tmr_done && keep_pump && !stop_entry
		|=> pump_q ##1 (state_q == S_PROG) && pump_q) else $error("pump dropped inside burst row");
	a_row_break: assert property ((state_q == S_PROG) && tmr_done && (act_cmd_q == CMD_BURST)
		&& !cbef_q && (buf_cmd_q == CMD_BURST) && !same_row |=> !pump_q) else $error("pump held across row");
	a_pump_busy: assert property ((state_q == S_PROG || state_q == S_ERASE) |-> pump_q)
		else $error("pump off during operation");
	a_pump_done: assert property ((state_q == S_ERASE) && tmr_done |=> !pump_q)
		else $error("pump on after erase");
	a_illegal_code: assert property (wr_cmd && cbef_q && !legal_code(pwdata[7:0])
		|=> accerr_q && $stable(cmd_q)) else $error("illegal code not rejected");
	a_nodiv_err: assert property (launch_try && cmd_vld_q && (cmd_q != CMD_BLANK) && !div_set_q
		|=> accerr_q && cbef_q) else $error("launch without divider accepted");
	a_stop_err: assert property (stop_entry && (state_q != S_IDLE)
		|=> accerr_q && (state_q == S_IDLE) && !pump_q) else $error("stop entry not flagged");
	a_accerr_keep: assert property (accerr_q && wr_st && !pwdata[ST_ACCERR] |=> accerr_q)
		else $error("error flag lost on zero write");
	a_accerr_clr: assert property (accerr_q && wr_st && pwdata[ST_ACCERR] && !err_ev |=> !accerr_q)
		else $error("error flag not cleared");
	a_blank_set: assert property ((state_q == S_BLANK_CMP) && (scan_q == {ADDR_W{1'b1}})
		&& (arr_rdata == ERASED_BYTE) && scan_ok_q |=> blank_q) else $error("blank flag not set");
	a_blank_fail: assert property ((state_q == S_BLANK_CMP) && (arr_rdata != ERASED_BYTE) && !launch_ok
		|=> !blank_q && (state_q == S_IDLE)) else $error("dirty array reported blank");
	a_blank_clr: assert property (launch_ok && (state_q != S_BLANK_CMP) |=> !blank_q)
		else $error("blank flag kept over launch");
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
	import flash_seq_pkg::*;
	// Small array and short erases keep the run brief
	localparam int AW = 7, PG = 50, MS = 80;
	// Code, error expected, strobes seen {rd, mass, page, prog}
	typedef struct {logic [7:0] code; logic err; logic [3:0] seen;} row_s;
	row_s rows [9] = '{'{8'h05, 1'b0, 4'h8}, '{8'h20, 1'b0, 4'h1}, '{8'h25, 1'b0, 4'h1},
		'{8'h40, 1'b0, 4'h2}, '{8'h41, 1'b0, 4'h4}, '{8'h00, 1'b1, 4'h0}, '{8'h24, 1'b1, 4'h0},
		'{8'h33, 1'b1, 4'h0}, '{8'hff, 1'b1, 4'h0}};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, stop_entry, mon_clr, pump_prev, err_seen;
	logic [7:0] paddr, arr_wdata, arr_rdata;
	logic [31:0] pwdata, prdata, rdv;
	logic [AW-1:0] arr_addr;
	logic arr_rd, arr_prog, arr_page_erase, arr_mass_erase, pump_en;
	logic [7:0] mem [2**AW];
	logic [3:0] seen = 4'h0;
	int falls = 0, cycles = 0, n_errors = 0, checks_done = 0;
	flash_command_sequencer #(.ADDR_W(AW), .PAGE_CYCLES(PG), .MASS_CYCLES(MS)) dut_u (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .stop_entry(stop_entry),
		.arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata), .arr_rd(arr_rd),
		.arr_prog(arr_prog), .arr_page_erase(arr_page_erase), .arr_mass_erase(arr_mass_erase),
		.pump_en(pump_en));
	// Array answers in the same cycle
	assign arr_rdata = mem[arr_addr];
	// Clock at 10 MHz
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// Strobe and pump-drop watcher
	always @(posedge pclk) begin
		pump_prev <= pump_en;
		if (mon_clr) begin
			seen <= 4'h0;
			falls <= 0;
		end else begin
			seen <= seen | {arr_rd, arr_mass_erase, arr_page_erase, arr_prog};
			if (pump_prev && !pump_en) begin
				falls <= falls + 1;
			end
		end
	end
	// Hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (n_errors == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Word compare
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Flag compare
	task automatic chk_bit(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask
	// One APB transfer; results taken at the pready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdv = prdata;
		err_seen = pslverr;
		if (n >= 20) begin
			chk_bit("pready", 1'b1, 1'b0);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Address, data, code, then launch
	task automatic cmd(input logic [7:0] code, input logic [7:0] a);
		apb(1'b1, OFS_ADDR, {24'h0, a});
		apb(1'b1, OFS_DATA, {24'h0, a});
		apb(1'b1, OFS_CMD, {24'h0, code});
		apb(1'b1, OFS_STATUS, 32'h80);
	endtask
	// Poll status until idle; last status word left in rdv
	task automatic idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, OFS_STATUS, 32'h0);
			n++;
		end while (!(rdv[ST_CBEF] === 1'b1 && rdv[ST_CCF] === 1'b1) && n < 500);
		if (n >= 500) begin
			chk_bit("command_complete_flag", 1'b1, 1'b0);
		end
	endtask
	task automatic clr_mon();
		@(posedge pclk);
		mon_clr <= 1'b1;
		@(posedge pclk);
		mon_clr <= 1'b0;
	endtask
	// Second command queued while the first runs
	task automatic pair(input logic [7:0] code, input logic [7:0] a, input int exp);
		clr_mon();
		cmd(code, a);
		cmd(code, a + 8'h01);
		idle();
		chk("pump_drops", 32'(exp), 32'(falls));
		chk_bit("pump_idle", 1'b0, pump_en);
		chk_bit("err_pair", 1'b0, rdv[ST_ACCERR]);
		chk("arr_addr", 32'(a + 8'h01), 32'(arr_addr));
		chk("arr_wdata", 32'(a + 8'h01), 32'(arr_wdata));
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		stop_entry = 1'b0;
		mon_clr = 1'b0;
		foreach (mem[i]) mem[i] = ERASED_BYTE;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("status_reset", 32'hc0, rdv);
		apb(1'b0, OFS_CLKDIV, 32'h0);
		chk("divider_reset", 32'h0, rdv);
		apb(1'b0, OFS_INT_MASK, 32'h0);
		chk("int_mask_reset", 32'h0, rdv);
		chk_bit("pump_reset", 1'b0, pump_en);
		// Program before the divider is set up must be refused
		clr_mon();
		cmd(CMD_BYTE, 8'h00);
		idle();
		chk_bit("err_no_div", 1'b1, rdv[ST_ACCERR]);
		chk("strobes_no_div", 32'h0, {28'h0, seen});
		apb(1'b1, OFS_STATUS, 32'h10);
		// Unmapped place
		apb(1'b0, 8'h40, 32'h0);
		chk_bit("slverr", 1'b1, err_seen);
		chk("unmapped", 32'h0, rdv);
		apb(1'b1, OFS_CLKDIV, 32'h05);
		apb(1'b0, OFS_CLKDIV, 32'h0);
		chk("divider", 32'h85, rdv);
		// Empty launch, then zero and one writes to the error flag
		apb(1'b1, OFS_STATUS, 32'h80);
		apb(1'b1, OFS_STATUS, 32'h00);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk_bit("err_empty_launch", 1'b1, rdv[ST_ACCERR]);
		apb(1'b1, OFS_STATUS, 32'h10);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk_bit("err_cleared", 1'b0, rdv[ST_ACCERR]);
		// Every legal code and a spread of illegal ones
		foreach (rows[i]) begin
			clr_mon();
			cmd(rows[i].code, 8'h00);
			idle();
			chk_bit("err_code", rows[i].err, rdv[ST_ACCERR]);
			chk("strobes", {28'h0, rows[i].seen}, {28'h0, seen});
			apb(1'b1, OFS_STATUS, 32'h10);
		end
		// Blank check: clean, direct write, dirty
		cmd(CMD_BLANK, 8'h00);
		idle();
		chk_bit("blank_clean", 1'b1, rdv[ST_BLANK]);
		apb(1'b1, OFS_STATUS, 32'h04);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk_bit("blank_write", 1'b1, rdv[ST_BLANK]);
		mem[100] <= 8'h00;
		cmd(CMD_BLANK, 8'h00);
		idle();
		chk_bit("blank_dirty", 1'b0, rdv[ST_BLANK]);
		mem[100] <= ERASED_BYTE;
		// Completion interrupt: masked, unmasked, cleared
		apb(1'b1, OFS_INT_ST, 32'h3);
		cmd(CMD_BLANK, 8'h00);
		idle();
		chk_bit("irq_masked", 1'b0, irq);
		apb(1'b0, OFS_INT_ST, 32'h0);
		chk("int_done", 32'h1, rdv & 32'h1);
		apb(1'b1, OFS_INT_MASK, 32'h1);
		repeat (2) @(posedge pclk);
		chk_bit("irq_on", 1'b1, irq);
		apb(1'b1, OFS_INT_ST, 32'h1);
		repeat (2) @(posedge pclk);
		chk_bit("irq_off", 1'b0, irq);
		// Pump holding across queued bytes
		pair(CMD_BURST, 8'd10, 1);
		pair(CMD_BURST, 8'd63, 2);
		pair(CMD_BYTE, 8'd10, 2);
		// Stop entry in mid-erase
		cmd(CMD_PAGE, 8'h00);
		repeat (5) @(posedge pclk);
		stop_entry <= 1'b1;
		@(posedge pclk);
		stop_entry <= 1'b0;
		repeat (3) @(posedge pclk);
		chk_bit("pump_stop", 1'b0, pump_en);
		chk_bit("erase_stop", 1'b0, arr_page_erase);
		idle();
		chk_bit("err_stop", 1'b1, rdv[ST_ACCERR]);
		give_verdict();
	end
endmodule
